// ### design/dtm_ctrl.sv
// Reference, monitor and toggle control of the 40-channel converter
//
// Contract
// - External reference selected after any reset
// - Control bit picks internal 2.5 or 1.25 V
// - Control bit switches to internal reference
// - Reset waits brownout time, reloads calibration
// - Monitor mux routes one channel out
// - Last channel carries monitor while enabled
// - Monitor selection needs monitor enabled first
// - Monitor address 63 three-states the output
// - Select zero, address 001100 writes control
// - Five control bits enable eight-channel groups
// - Every channel holds A and B registers
// - B writes accepted only with toggle enabled
// - Each load strobe alternates toggled outputs
// - First strobe after enabling shows A
// - First strobe after disabling shows A
// - Destination select bits choose target register
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
module dtm_ctrl #(
  parameter int POR_CYCLES = dtm_pkg::DTM_POR_CYCLES,
  parameter int CAL_CYCLES = dtm_pkg::DTM_CAL_LOAD_CYCLES,
  parameter int NUM_CH     = dtm_pkg::DTM_NUM_CH
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire dtm_pkg::dtm_bus_req_s bus_req,
  output logic [13:0]               rd_data,
  input  wire logic                 output_load_strobe_n,
  output logic [NUM_CH*14-1:0]      dac_code,
  output logic                      last_channel_output_oe,
  output logic                      shared_monitor_active,
  output logic                      internal_ref_enable,
  output logic                      ref_value_2v5,
  output logic                      dev_ready
);
  import dtm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [13:0] ctrl;
    logic [5:0]  mon_sel;
    logic [13:0] rd_data;
    logic [13:0] last_code;
    logic        last_oe;
    logic        strobe_d;
    logic        soft_rst;
  } dtm_ctrl_s;

  dtm_ctrl_s s_r;
  dtm_ctrl_s s_nxt;

  logic        por_busy;
  logic        por_done;
  logic        cal_busy;
  logic        busy;
  logic        wr_ok;
  logic        ch_hit;
  logic        spc_wr;
  logic        load;
  logic        mon_en;
  logic        chan_clr;
  logic [13:0] a_code   [NUM_CH];
  logic [13:0] b_code   [NUM_CH];
  logic [13:0] out_code [NUM_CH];
  logic [NUM_CH-1:0] wr_a_vec;
  logic [NUM_CH-1:0] wr_b_vec;
  logic [NUM_CH-1:0] tog_en_vec;

  // ****************************************************************
  // Power-on wait and calibration reload
  // ****************************************************************

  // Brownout wait starts loaded out of reset, so no write or load strobe is accepted
  // until the supply has had its full settling time
  dtm_delay_timer #(
    .COUNT        (POR_CYCLES),
    .START_LOADED (1'b1)
  ) u_por_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (1'b0),
    .busy    (por_busy),
    .done    (por_done)
  );

  // Calibration reload follows the brownout wait and every soft reset
  dtm_delay_timer #(
    .COUNT        (CAL_CYCLES),
    .START_LOADED (1'b0)
  ) u_cal_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (por_done | s_r.soft_rst),
    .busy    (cal_busy),
    .done    ()
  );

  // Host writes and load strobes are refused during either wait; reads still answer
  // The done cycle of the brownout wait counts as busy, otherwise a
  // one-cycle ready window would open before the reload starts
  assign busy      = por_busy | por_done | cal_busy | s_r.soft_rst;
  assign dev_ready = ~busy;
  assign chan_clr  = s_r.soft_rst;

  // ****************************************************************
  // Write decode
  // ****************************************************************

  // Qualified write and its coarse target
  assign wr_ok  = bus_req.wr & ~busy;
  assign ch_hit = ({26'h000_0000, bus_req.addr} < NUM_CH);
  assign spc_wr = wr_ok & (bus_req.sel == DTM_SEL_SPC);
  assign mon_en = s_r.ctrl[DTM_CR_MON_EN_BIT];

  // Falling edge of the active low load strobe; inputs are synchronous
  assign load = s_r.strobe_d & ~output_load_strobe_n & ~busy;

  // ****************************************************************
  // Channels
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // Channel strobes from the destination select and address
      assign wr_a_vec[gi] = wr_ok & ch_hit & (bus_req.sel == DTM_SEL_A)
                            & (bus_req.addr == 6'(gi));
      assign wr_b_vec[gi] = wr_ok & ch_hit & (bus_req.sel == DTM_SEL_B)
                            & (bus_req.addr == 6'(gi));
      // One enable bit per group of eight channels
      assign tog_en_vec[gi] =
        s_r.ctrl[DTM_CR_TOG_LO_BIT + gi / DTM_GROUP_SIZE];

      dtm_toggle_channel u_ch (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clr      (chan_clr),
        .wr_a     (wr_a_vec[gi]),
        .wr_b     (wr_b_vec[gi]),
        .wdata    (bus_req.wdata),
        .tog_en   (tog_en_vec[gi]),
        .load     (load),
        .a_code   (a_code[gi]),
        .b_code   (b_code[gi]),
        .out_code (out_code[gi])
      );

      // All but the last channel drive their own latched code
      if (gi < NUM_CH - 1) begin : g_plain
        assign dac_code[gi*14 +: 14] = out_code[gi];
      end
    end
  endgenerate

  // Last channel output is the registered monitor or channel code
  assign dac_code[(NUM_CH-1)*14 +: 14] = s_r.last_code;
  assign last_channel_output_oe        = s_r.last_oe;
  assign shared_monitor_active         = mon_en;

  // ****************************************************************
  // Control, monitor and readback
  // ****************************************************************

  // Next state of the control side; reads answer for one cycle only
  always_comb begin
    s_nxt          = s_r;
    s_nxt.strobe_d = output_load_strobe_n;
    s_nxt.soft_rst = 1'b0;
    s_nxt.rd_data  = '0;
    // Special function writes
    if (spc_wr) begin
      case (bus_req.addr)
        DTM_SPC_CTRL: begin
          s_nxt.ctrl = bus_req.wdata;
        end
        DTM_SPC_MON: begin
          if (mon_en) begin
            s_nxt.mon_sel = bus_req.wdata[5:0];
          end
        end
        DTM_SPC_SOFT_RST: begin
          s_nxt.soft_rst = 1'b1;
        end
        default: begin
          s_nxt.soft_rst = 1'b0;
        end
      endcase
    end
    // User reset returns to defaults, external reference included
    if (s_r.soft_rst) begin
      s_nxt.ctrl    = DTM_CTRL_RESET;
      s_nxt.mon_sel = DTM_MON_TRISTATE;
    end
    // Last channel: monitor path while enabled, else its own code
    if (mon_en) begin
      s_nxt.last_oe = (s_r.mon_sel != DTM_MON_TRISTATE);
      if ({26'h000_0000, s_r.mon_sel} < NUM_CH) begin
        s_nxt.last_code = out_code[s_r.mon_sel];
      end else begin
        s_nxt.last_code = '0;
      end
    end else begin
      s_nxt.last_oe   = 1'b1;
      s_nxt.last_code = out_code[NUM_CH-1];
    end
    // Readback of stored values and state
    if (bus_req.rd) begin
      case (bus_req.sel)
        DTM_SEL_A: begin
          if (ch_hit) begin
            s_nxt.rd_data = a_code[bus_req.addr];
          end
        end
        DTM_SEL_B: begin
          if (ch_hit) begin
            s_nxt.rd_data = b_code[bus_req.addr];
          end
        end
        DTM_SEL_SPC: begin
          if (bus_req.addr == DTM_SPC_CTRL) begin
            s_nxt.rd_data = s_r.ctrl;
          end else if (bus_req.addr == DTM_SPC_MON) begin
            s_nxt.rd_data = {8'h00, s_r.mon_sel};
          end else if (bus_req.addr == DTM_SPC_STATUS) begin
            s_nxt.rd_data[DTM_ST_POR_BIT] = por_busy;
            s_nxt.rd_data[DTM_ST_CAL_BIT] = cal_busy;
            s_nxt.rd_data[DTM_ST_MON_BIT] = mon_en;
          end
        end
        default: begin
          s_nxt.rd_data = '0;
        end
      endcase
    end
  end

  // State register; reset leaves the external reference selected
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '{ctrl:      DTM_CTRL_RESET,
               mon_sel:   DTM_MON_TRISTATE,
               rd_data:   14'h0000,
               last_code: 14'h0000,
               last_oe:   1'b1,
               strobe_d:  1'b1,
               soft_rst:  1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Reference steering straight from the control register
  assign internal_ref_enable = s_r.ctrl[DTM_CR_INT_REF_BIT];
  assign ref_value_2v5       = s_r.ctrl[DTM_CR_REF_VAL_BIT];
  assign rd_data             = s_r.rd_data;

endmodule // dtm_ctrl

// ### design/dtm_pkg.sv
// Shared constants and types of the toggle and monitor control block
package dtm_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int DTM_NUM_CH     = 40;
  localparam int DTM_DATA_W     = 14;
  localparam int DTM_ADDR_W     = 6;
  localparam int DTM_GROUP_SIZE = 8;
  localparam int DTM_NUM_GROUPS = 5;

  // ****************************************************************
  // Destination select codes and special function addresses
  // ****************************************************************
  localparam logic [1:0] DTM_SEL_SPC = 2'h0;
  localparam logic [1:0] DTM_SEL_B   = 2'h2;
  localparam logic [1:0] DTM_SEL_A   = 2'h3;

  localparam logic [5:0] DTM_SPC_MON      = 6'h0A;
  localparam logic [5:0] DTM_SPC_CTRL     = 6'h0C;
  localparam logic [5:0] DTM_SPC_STATUS   = 6'h0D;
  localparam logic [5:0] DTM_SPC_SOFT_RST = 6'h0F;
  localparam logic [5:0] DTM_MON_TRISTATE = 6'h3F;

  // ****************************************************************
  // Control register fields and reset value
  // ****************************************************************
  localparam int DTM_CR_MON_EN_BIT   = 0;
  localparam int DTM_CR_TOG_LO_BIT   = 2;
  localparam int DTM_CR_INT_REF_BIT  = 10;
  localparam int DTM_CR_REF_VAL_BIT  = 12;
  localparam logic [13:0] DTM_CTRL_RESET = 14'h0000;

  // Status word fields
  localparam int DTM_ST_POR_BIT = 0;
  localparam int DTM_ST_CAL_BIT = 1;
  localparam int DTM_ST_MON_BIT = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint DTM_CLK_HZ         = 50_000_000;
  localparam longint DTM_POR_BROWNOUT_MS = 10;
  localparam int DTM_POR_CYCLES =
    int'((DTM_POR_BROWNOUT_MS * DTM_CLK_HZ + 999) / 1000);
  localparam int DTM_CAL_LOAD_CYCLES = DTM_NUM_CH;

  // ****************************************************************
  // Host request carrier
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [5:0]  addr;
    logic [13:0] wdata;
  } dtm_bus_req_s;

endpackage

// ### design/dtm_delay_timer.sv
// Down counter that holds busy for a fixed number of cycles
`timescale 1ns/100ps
module dtm_delay_timer #(
  parameter int   COUNT        = 16,
  parameter logic START_LOADED = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import dtm_pkg::*;

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD_CNT  = CW'(COUNT);
  localparam logic [CW-1:0] RESET_CNT = START_LOADED ? CW'(COUNT) : '0;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } dtm_tmr_s;

  dtm_tmr_s s_r;
  dtm_tmr_s s_nxt;

  // Restart wins over counting so a new request always waits the full time
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.cnt = LOAD_CNT;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt  = s_r.cnt - CW'(1);
      s_nxt.done = (s_r.cnt == CW'(1));
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '{cnt: RESET_CNT, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.cnt != '0);
  assign done = s_r.done;

endmodule // dtm_delay_timer

// ### design/dtm_toggle_channel.sv
// One channel: A and B data registers and the toggling output latch
`timescale 1ns/100ps
module dtm_toggle_channel (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic        wr_a,
  input  wire logic        wr_b,
  input  wire logic [13:0] wdata,
  input  wire logic        tog_en,
  input  wire logic        load,
  output logic [13:0]      a_code,
  output logic [13:0]      b_code,
  output logic [13:0]      out_code
);
  import dtm_pkg::*;

  typedef struct packed {
    logic [13:0] a;
    logic [13:0] b;
    logic [13:0] out;
    logic        next_b;
    logic        tog_en_d;
  } dtm_chan_s;

  dtm_chan_s s_r;
  dtm_chan_s s_nxt;

  // Data capture and load; a load in the cycle of an A write uses the old A
  always_comb begin
    logic next_b;
    next_b         = s_r.next_b;
    s_nxt          = s_r;
    s_nxt.tog_en_d = tog_en;
    if (tog_en != s_r.tog_en_d) begin
      next_b = 1'b0;
    end
    if (wr_a) begin
      s_nxt.a = wdata;
    end
    if (wr_b && tog_en) begin
      s_nxt.b = wdata;
    end
    if (load) begin
      if (tog_en) begin
        s_nxt.out = next_b ? s_r.b : s_r.a;
        next_b    = ~next_b;
      end else begin
        s_nxt.out = s_r.a;
        next_b    = 1'b0;
      end
    end
    s_nxt.next_b = next_b;
    if (clr) begin
      s_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign a_code   = s_r.a;
  assign b_code   = s_r.b;
  assign out_code = s_r.out;

endmodule // dtm_toggle_channel

// ### testbench/dtm_ctrl_props.sv
// Concurrent checks on the ports of the control block
`timescale 1ns/100ps
module dtm_ctrl_props #(
  parameter int POR_CYCLES = 20,
  parameter int CAL_CYCLES = 4,
  parameter int NUM_CH     = 40
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire dtm_pkg::dtm_bus_req_s  bus_req,
  input wire logic [13:0]            rd_data,
  input wire logic                   output_load_strobe_n,
  input wire logic [NUM_CH*14-1:0]   dac_code,
  input wire logic                   last_channel_output_oe,
  input wire logic                   shared_monitor_active,
  input wire logic                   internal_ref_enable,
  input wire logic                   ref_value_2v5,
  input wire logic                   dev_ready
);
  import dtm_pkg::*;
  // ****************************************
  // Helper history and step sequences
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  logic [1:0]  stb_q;
  logic [13:0] wd_q;
  // Strobe history: 2'b10 means a falling edge was sampled one cycle ago
  always_ff @(posedge sys_clk) begin
    stb_q <= {stb_q[0], output_load_strobe_n};
    wd_q  <= bus_req.wdata;
  end
  sequence s_spc_wr;
    bus_req.wr && dev_ready && bus_req.sel == DTM_SEL_SPC;
  endsequence
  sequence s_ctrl_wr;
    s_spc_wr ##0 bus_req.addr == DTM_SPC_CTRL;
  endsequence
  sequence s_tri_wr;
    s_spc_wr ##0 bus_req.addr == DTM_SPC_MON && bus_req.wdata[5:0] == DTM_MON_TRISTATE
      ##0 shared_monitor_active;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_RST_REF: assert property (rst |=> !internal_ref_enable && !shared_monitor_active
    && last_channel_output_oe) else $error("reference or monitor wrong after reset");
  AST_RST_BUSY: assert property (rst ##1 !rst |-> !dev_ready [*8])
    else $error("ready too early after reset");
  AST_INT_REF: assert property (disable iff (rst) s_ctrl_wr |=>
    internal_ref_enable == wd_q[DTM_CR_INT_REF_BIT]) else $error("internal ref bit");
  AST_REF_VAL: assert property (disable iff (rst) s_ctrl_wr |=>
    ref_value_2v5 == wd_q[DTM_CR_REF_VAL_BIT]) else $error("reference value bit");
  AST_MON_EN: assert property (disable iff (rst) s_ctrl_wr |=>
    shared_monitor_active == wd_q[DTM_CR_MON_EN_BIT]) else $error("monitor enable bit");
  AST_TRI: assert property (disable iff (rst) !last_channel_output_oe |->
    shared_monitor_active || $past(shared_monitor_active)) else $error("oe low, monitor off");
  AST_TRI_SEL: assert property (disable iff (rst) s_tri_wr |->
    ##[1:2] !last_channel_output_oe) else $error("select 63 left output driven");
  AST_RD_IDLE: assert property (disable iff (rst) !bus_req.rd |=>
    rd_data == 14'h0000) else $error("read data without read");
  AST_LOAD: assert property (disable iff (rst) $changed(dac_code[NUM_CH*14-15:0]) |->
    stb_q == 2'b10 || !dev_ready || !$past(dev_ready)) else $error("output moved without load");
endmodule // dtm_ctrl_props

bind dtm_ctrl dtm_ctrl_props #(
  .POR_CYCLES(POR_CYCLES), .CAL_CYCLES(CAL_CYCLES), .NUM_CH(NUM_CH)
) u_props (
  .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
  .output_load_strobe_n(output_load_strobe_n), .dac_code(dac_code),
  .last_channel_output_oe(last_channel_output_oe),
  .shared_monitor_active(shared_monitor_active),
  .internal_ref_enable(internal_ref_enable), .ref_value_2v5(ref_value_2v5),
  .dev_ready(dev_ready)
);

// ### testbench/dtm_host_model.sv
// Host model issuing register accesses and load strobes
`timescale 1ns/100ps
module dtm_host_model (
  input  wire logic             sys_clk,
  input  wire logic [13:0]      rd_data,
  output dtm_pkg::dtm_bus_req_s bus_req,
  output logic                  output_load_strobe_n
);
  import dtm_pkg::*;
  // ****************************************
  // Bus and strobe tasks
  // ****************************************
  initial begin
    bus_req = '0;
    output_load_strobe_n = 1'b1;
  end
  // Released fields are inverted so a stale value can never look valid
  task automatic wr(input logic [1:0] sel, input logic [5:0] addr, input logic [13:0] data);
    @(posedge sys_clk);
    bus_req <= '{1'b1, 1'b0, sel, addr, data};
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b0, ~sel, ~addr, ~data};
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] sel, input logic [5:0] addr, output logic [13:0] data);
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b1, sel, addr, 14'h0000};
    @(posedge sys_clk);
    bus_req <= '{1'b0, 1'b0, ~sel, ~addr, 14'h3FFF};
    #1 data = rd_data;
  endtask
  // Line returns high between pulses so every falling edge is seen
  task automatic load();
    @(posedge sys_clk);
    output_load_strobe_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    output_load_strobe_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule // dtm_host_model

// ### testbench/tb.sv
// Self-checking bench of the toggle and monitor control block
`timescale 1ns/100ps
module tb;
  import dtm_pkg::*;
  // ****************************************
  // Rows, signals and bench state
  // ****************************************
  typedef struct packed {
    logic [1:0]  sel;
    logic [5:0]  addr;
    logic [13:0] data;
    logic [13:0] exp;
  } dtm_row_s;
  localparam int POR = 20;
  localparam int CAL = 4;
  localparam dtm_row_s ROWS [8] = '{
    '{DTM_SEL_A, 6'h00, 14'h1111, 14'h1111},
    '{DTM_SEL_B, 6'h00, 14'h2222, 14'h2222},
    '{DTM_SEL_B, 6'h08, 14'h3333, 14'h0000}, // Group 1 off, B refused
    '{DTM_SEL_A, 6'h08, 14'h0444, 14'h0444},
    '{DTM_SEL_A, 6'h27, 14'h3FFF, 14'h3FFF},
    '{DTM_SEL_A, 6'h28, 14'h0555, 14'h0000}, // Beyond the last channel
    '{2'h1, 6'h01, 14'h0666, 14'h0000},
    '{DTM_SEL_SPC, 6'h01, 14'h0777, 14'h0000}
  };
  localparam logic [13:0] TOG [4] = '{14'h1111, 14'h2222, 14'h1111, 14'h2222};
  logic         sys_clk = 1'b0;
  logic         rst     = 1'b1;
  dtm_bus_req_s bus_req;
  logic         strobe_n;
  logic [13:0]  rd_data;
  logic [DTM_NUM_CH*14-1:0] dac_code;
  logic         oe, mon_act, int_ref, ref_2v5, dev_ready;
  logic [13:0]  d;
  int           error_cnt = 0;
  int           comparisons = 0;
  int           cycles = 0;
  int           n;

  dtm_ctrl #(.POR_CYCLES(POR), .CAL_CYCLES(CAL), .NUM_CH(DTM_NUM_CH)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .output_load_strobe_n(strobe_n), .dac_code(dac_code), .last_channel_output_oe(oe),
    .shared_monitor_active(mon_act), .internal_ref_enable(int_ref),
    .ref_value_2v5(ref_2v5), .dev_ready(dev_ready));
  dtm_host_model u_host (.sys_clk(sys_clk), .rd_data(rd_data), .bus_req(bus_req),
    .output_load_strobe_n(strobe_n));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ****************************************
  // Compare and helper tasks
  // ****************************************
  task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({13'h0000, got}, {13'h0000, exp});
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [13:0] ch(input int i);
    return dac_code[i*14+:14];
  endfunction
  task automatic gap();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (dev_ready !== 1'b1 && cnt < 200) begin
      @(posedge sys_clk);
      #1 cnt++;
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    wait_ready(n);
    cmp_bit(n >= POR + CAL && n <= POR + CAL + 2, 1'b1);
    cmp_bit(int_ref, 1'b0);
    cmp_bit(oe, 1'b1);
    // Internal reference at 2.5 V, then 1.25 V with toggle group 0 enabled first
    u_host.wr(DTM_SEL_SPC, DTM_SPC_CTRL, 14'h1400);
    gap();
    cmp_bit(int_ref, 1'b1);
    cmp_bit(ref_2v5, 1'b1);
    u_host.wr(DTM_SEL_SPC, DTM_SPC_CTRL, 14'h0404);
    gap();
    cmp_bit(ref_2v5, 1'b0);
    // Ordinary writes with read-back, A before B on channel 0, B before A on channel 8
    foreach (ROWS[i]) begin
      u_host.wr(ROWS[i].sel, ROWS[i].addr, ROWS[i].data);
      u_host.rd(ROWS[i].sel, ROWS[i].addr, d);
      cmp_word(d, ROWS[i].exp);
    end
    // Toggled group alternates A, B; untoggled channel stays on A
    for (int i = 0; i < 4; i++) begin
      u_host.load();
      #1 cmp_word(ch(0), TOG[i]);
      cmp_word(ch(8), 14'h0444);
    end
    u_host.wr(DTM_SEL_SPC, DTM_SPC_CTRL, 14'h0400);
    u_host.load();
    #1 cmp_word(ch(0), 14'h1111);
    cmp_word(ch(39), 14'h3FFF);
    // Monitor select is refused until enabled; then 63 floats the pin
    u_host.wr(DTM_SEL_SPC, DTM_SPC_MON, 14'h0000);
    u_host.wr(DTM_SEL_SPC, DTM_SPC_CTRL, 14'h0401);
    gap();
    cmp_bit(mon_act, 1'b1);
    cmp_bit(oe, 1'b0);
    u_host.rd(DTM_SEL_SPC, DTM_SPC_CTRL, d);
    cmp_word(d, 14'h0401);
    u_host.rd(DTM_SEL_SPC, DTM_SPC_STATUS, d);
    cmp_word(d, 14'h0004);
    u_host.wr(DTM_SEL_SPC, DTM_SPC_MON, 14'h0008);
    gap();
    cmp_bit(oe, 1'b1);
    cmp_word(ch(39), 14'h0444);
    u_host.wr(DTM_SEL_SPC, DTM_SPC_MON, 14'h0000);
    gap();
    cmp_word(ch(39), 14'h1111);
    // Unused channel addresses route code zero with the pin still driven
    u_host.wr(DTM_SEL_SPC, DTM_SPC_MON, 14'h0028);
    gap();
    cmp_word(ch(39), 14'h0000);
    cmp_bit(oe, 1'b1);
    u_host.wr(DTM_SEL_SPC, DTM_SPC_MON, 14'h003F);
    gap();
    cmp_bit(oe, 1'b0);
    // Soft reset clears state and reruns the reload
    u_host.wr(DTM_SEL_SPC, DTM_SPC_SOFT_RST, 14'h0000);
    gap();
    cmp_bit(dev_ready, 1'b0);
    wait_ready(n);
    cmp_bit(n > 0 && n <= CAL, 1'b1);
    cmp_word(ch(0), 14'h0000);
    cmp_bit(int_ref, 1'b0);
    u_host.rd(DTM_SEL_A, 6'h00, d);
    cmp_word(d, 14'h0000);
    print_verdict();
  end
endmodule // tb
